// ---- src/block_mixer.sv ----
/*
  Iterative 128-bit keyed block transform, one round per clock.
  Stand-in for the AES-128 core; same start/done handshake.
*/
`timescale 1ns/1ps
`default_nettype none

module block_mixer #(
  parameter int ROUNDS = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic start,
  input wire logic [127:0] din,
  input wire logic [127:0] key,
  // Answer
  output logic done,
  output logic [127:0] dout
);

  logic [127:0] state;
  logic [127:0] rkey;
  logic [4:0] round;
  logic busy;
  logic [127:0] next_state;
  logic [127:0] next_rkey;
  logic [4:0] next_round;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_state = state;
    next_rkey = rkey;
    next_round = round;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_state = din ^ key;
      next_rkey = key;
      next_round = 5'h00;
      next_busy = 1'b1;
    end else if (busy) begin
      next_rkey = {rkey[126:0], rkey[127]} ^ {120'h0, 3'h0, round};
      next_state = (state + {rkey[63:0], rkey[127:64]}) ^
                   {state[94:0], state[127:95]};
      next_round = round + 5'h01;
      if (round == 5'(ROUNDS - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= 128'h0;
      rkey <= 128'h0;
      round <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      rkey <= next_rkey;
      round <= next_round;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign dout = state;

endmodule // block_mixer

`default_nettype wire

// ---- src/byte_ram.sv ----
/*
  Internal byte RAM with a software port and an engine port.
  Reads are combinational; writes land on the clock edge, engine last.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_ram #(
  parameter int DEPTH = 768,
  parameter int AW = 10
) (
  // Clock
  input wire logic pclk,
  // Software port
  input wire logic [AW-1:0] sw_addr,
  input wire logic sw_we,
  input wire logic [7:0] sw_wdata,
  output logic [7:0] sw_q,
  // Engine port
  input wire logic [AW-1:0] eng_raddr,
  output logic [7:0] eng_q,
  input wire logic [AW-1:0] eng_waddr,
  input wire logic eng_we,
  input wire logic [7:0] eng_wdata
);

  logic [7:0] mem [DEPTH];

  assign sw_q = mem[sw_addr];
  assign eng_q = mem[eng_raddr];

  always_ff @(posedge pclk) begin
    if (sw_we) begin
      mem[sw_addr] <= sw_wdata;
    end
    // Engine write wins a same-address collision
    if (eng_we) begin
      mem[eng_waddr] <= eng_wdata;
    end
  end

endmodule // byte_ram

`default_nettype wire

// ---- src/ctr_decrypt_cbc_mac_unit.sv ----
/*
  Counter-mode decryption and chained MAC unit with APB registers,
  768-byte RAM, two priority slots and a sticky event register.
  Assumes an APB master on pclk; APB inputs need no synchroniser.
*/
// Behaviour
// - every finished instruction raises its priority's done event.
// - counter decryption runs the very same keystream XOR as encryption.
// - counter op takes priority, key, count, counter slot, source, dest.
// - MAC op takes priority, key, count, source, dest, 3-bit mode.
// - MAC reads count bytes from source, key at 16*slot, writes dest.
// - priority 0 is low, priority 1 is high.
// - MAC dest zero means writing right after the input data.
// - mode bits 1:0 give tag length 0, 4, 8 or 16 bytes.
// - mode bit 2 clear prepends the byte count to the data.
// - mode bit 2 set authenticates data with no length prefix.
// - issuing to a busy priority raises the busy error event.
// - counter op key at 16*key slot, counter at 16*counter slot.
// - counter op dest zero overwrites the source data in place.
`timescale 1ns/1ps
`default_nettype none
`include "ctr_mac_map.svh"

module ctr_decrypt_cbc_mac_unit
  import ctr_mac_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq
);
  import ctr_mac_pkg::*;

  // Software-facing state
  instr_type opnd;
  instr_type slot [2];
  logic [1:0] active;
  logic [`CM_EV_W-1:0] status;
  logic [`CM_EV_W-1:0] mask;
  instr_type next_opnd;
  instr_type next_slot [2];
  logic [1:0] next_active;
  logic [`CM_EV_W-1:0] next_status;
  logic [`CM_EV_W-1:0] next_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  // Engine state
  eng_state_type state;
  instr_type cur;
  logic cur_prio;
  logic [127:0] key;
  logic [127:0] blk;
  logic [127:0] ks;
  logic [7:0] idx;
  logic [7:0] len;
  logic [3:0] pos;
  logic [4:0] tag_len;
  logic [11:0] dst_eff;
  logic launch;
  logic [`CM_EV_W-1:0] eng_ev;
  eng_state_type next_state;
  instr_type next_cur;
  logic next_cur_prio;
  logic [127:0] next_key;
  logic [127:0] next_blk;
  logic [127:0] next_ks;
  logic [7:0] next_idx;
  logic [7:0] next_len;
  logic [3:0] next_pos;
  logic [4:0] next_tag_len;
  logic [11:0] next_dst_eff;
  logic next_launch;
  logic [`CM_EV_W-1:0] next_eng_ev;

  // Glue
  logic access;
  logic commit;
  logic ram_hit;
  logic reg_hit;
  logic [31:0] reg_rd;
  logic [7:0] sw_q;
  logic [7:0] eng_q;
  logic [`CM_RAM_AW-1:0] eng_raddr;
  logic [`CM_RAM_AW-1:0] eng_waddr;
  logic eng_we;
  logic [7:0] eng_wdata;
  logic mix_done;
  logic [127:0] mix_out;
  logic is_mac;
  logic prefix;
  logic [12:0] src_end;
  logic [12:0] dst_end;
  logic [4:0] mode_tag;
  logic [11:0] eff_dst;
  logic [7:0] byte_in;

  byte_ram #(
    .DEPTH(768),
    .AW(`CM_RAM_AW)
  ) u_ram (
    .pclk(pclk),
    .sw_addr(paddr[`CM_RAM_AW+1:2]),
    .sw_we(commit && pwrite && ram_hit),
    .sw_wdata(pwdata[7:0]),
    .sw_q(sw_q),
    .eng_raddr(eng_raddr),
    .eng_q(eng_q),
    .eng_waddr(eng_waddr),
    .eng_we(eng_we),
    .eng_wdata(eng_wdata)
  );

  block_mixer #(
    .ROUNDS(`CM_CIPHER_ROUNDS)
  ) u_mix (
    .pclk(pclk),
    .presetn(presetn),
    .start(launch),
    .din(blk),
    .key(key),
    .done(mix_done),
    .dout(mix_out)
  );

  // APB decode; one wait state on every access
  assign access = psel && penable && !pready;
  assign commit = psel && penable && pready;
  assign ram_hit = paddr[`CM_RAM_SEL_BIT] &&
                   ({3'h0, paddr[11:2]} < `CM_RAM_BYTES);

  always_comb begin
    reg_hit = 1'b1;
    reg_rd = 32'h0000_0000;
    unique case (paddr)
      `CM_REG_CMD: reg_rd = 32'h0000_0000;
      `CM_REG_KEY_SLOT: reg_rd = {24'h0, opnd.key};
      `CM_REG_COUNT: reg_rd = {25'h0, opnd.cnt};
      `CM_REG_CTR_SLOT: reg_rd = {24'h0, opnd.ctr};
      `CM_REG_SRC: reg_rd = {20'h0, opnd.src};
      `CM_REG_DST: reg_rd = {20'h0, opnd.dst};
      `CM_REG_MODE: reg_rd = {29'h0, opnd.mode};
      `CM_REG_STATUS: reg_rd = {27'h0, status};
      `CM_REG_MASK: reg_rd = {27'h0, mask};
      `CM_REG_ACTIVE: reg_rd = {29'h0, state != st_idle, active};
      default: reg_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_opnd = opnd;
    next_slot = slot;
    next_active = active;
    next_mask = mask;
    next_pready = access;
    next_prdata = 32'h0000_0000;
    next_pslverr = access && !(reg_hit || ram_hit);
    next_status = status;
    if (access && !pwrite) begin
      next_prdata = ram_hit ? {24'h0, sw_q} : reg_rd;
    end
    if (commit && pwrite && reg_hit) begin
      unique case (paddr)
        `CM_REG_KEY_SLOT: next_opnd.key = pwdata[7:0];
        `CM_REG_COUNT: next_opnd.cnt = pwdata[6:0];
        `CM_REG_CTR_SLOT: next_opnd.ctr = pwdata[7:0];
        `CM_REG_SRC: next_opnd.src = pwdata[11:0];
        `CM_REG_DST: next_opnd.dst = pwdata[11:0];
        `CM_REG_MODE: next_opnd.mode = pwdata[2:0];
        `CM_REG_STATUS: next_status = status & ~pwdata[`CM_EV_W-1:0];
        `CM_REG_MASK: next_mask = pwdata[`CM_EV_W-1:0];
        `CM_REG_CMD: begin
          // Bit selects priority: 0 low, 1 high
          if (op_type'(pwdata[`CM_CMD_OP]) != op_none) begin
            if (active[pwdata[`CM_CMD_PRIO]]) begin
              next_status[`CM_EV_BUSY] = 1'b1;
            end else begin
              next_active[pwdata[`CM_CMD_PRIO]] = 1'b1;
              next_slot[pwdata[`CM_CMD_PRIO]] = opnd;
              next_slot[pwdata[`CM_CMD_PRIO]].op =
                op_type'(pwdata[`CM_CMD_OP]);
            end
          end
        end
        default: next_opnd = opnd;
      endcase
    end
    if (state == st_finish) begin
      next_active[cur_prio] = 1'b0;
    end
    // Hardware set wins over a same-cycle software clear
    next_status = next_status | eng_ev;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd <= '0;
      slot[0] <= '0;
      slot[1] <= '0;
      active <= 2'h0;
      status <= '0;
      mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      opnd <= next_opnd;
      slot <= next_slot;
      active <= next_active;
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // Operand checks on the selected instruction
  assign is_mac = (cur.op == chained_mac_auth_op);
  assign prefix = !cur.mode[`CM_MODE_NOPREFIX];
  always_comb begin
    unique case (cur.mode[1:0])
      2'h1: mode_tag = `CM_TAG_LEN1;
      2'h2: mode_tag = `CM_TAG_LEN2;
      2'h3: mode_tag = `CM_TAG_LEN3;
      default: mode_tag = 5'h00;
    endcase
  end
  assign src_end = {1'b0, cur.src} + {6'h0, cur.cnt};
  always_comb begin
    if (cur.dst != 12'h000) begin
      eff_dst = cur.dst;
    end else if (is_mac) begin
      eff_dst = src_end[11:0];
    end else begin
      eff_dst = cur.src;
    end
  end
  assign dst_end = {1'b0, eff_dst} +
                   (is_mac ? {8'h0, mode_tag} : {6'h0, cur.cnt});
  assign byte_in = (prefix && idx == 8'h00) ? {1'b0, cur.cnt} : eng_q;

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_cur_prio = cur_prio;
    next_key = key;
    next_blk = blk;
    next_ks = ks;
    next_idx = idx;
    next_len = len;
    next_pos = pos;
    next_tag_len = tag_len;
    next_dst_eff = dst_eff;
    next_launch = 1'b0;
    next_eng_ev = '0;
    eng_raddr = '0;
    eng_waddr = '0;
    eng_we = 1'b0;
    eng_wdata = 8'h00;
    unique case (state)
      st_idle: begin
        if (active[1]) begin
          next_cur = slot[1];
          next_cur_prio = 1'b1;
          next_state = st_check;
        end else if (active[0]) begin
          next_cur = slot[0];
          next_cur_prio = 1'b0;
          next_state = st_check;
        end
      end
      st_check: begin
        next_pos = 4'h0;
        next_idx = 8'h00;
        next_dst_eff = eff_dst;
        next_tag_len = mode_tag;
        next_len = {1'b0, cur.cnt} + {7'h0, prefix && is_mac};
        if (is_mac && cur.cnt == 7'h00 && !prefix && mode_tag != 5'h00) begin
          next_eng_ev[`CM_EV_OPERAND] = 1'b1;
          next_state = st_finish;
        end else if (cur.key >= `CM_SLOT_LIMIT || src_end > `CM_RAM_BYTES ||
                     dst_end > `CM_RAM_BYTES ||
                     (!is_mac && cur.ctr >= `CM_SLOT_LIMIT)) begin
          next_eng_ev[`CM_EV_MEMADDR] = 1'b1;
          next_state = st_finish;
        end else begin
          next_state = st_key;
        end
      end
      st_key: begin
        eng_raddr = {cur.key[5:0], pos};
        next_key[pos*8 +: 8] = eng_q;
        next_pos = pos + 4'h1;
        if (pos == `CM_LAST_POS) begin
          next_blk = 128'h0;
          if (!is_mac) begin
            next_state = st_ctr;
          end else if (len == 8'h00) begin
            next_state = st_tag;
          end else begin
            next_state = st_absorb;
          end
        end
      end
      st_ctr: begin
        eng_raddr = {cur.ctr[5:0], pos};
        next_blk[pos*8 +: 8] = eng_q;
        next_pos = pos + 4'h1;
        if (pos == `CM_LAST_POS) begin
          next_launch = (cur.cnt != 7'h00);
          next_state = (cur.cnt != 7'h00) ? st_cipher : st_finish;
        end
      end
      st_cipher: begin
        if (mix_done) begin
          next_pos = 4'h0;
          if (!is_mac) begin
            next_ks = mix_out;
            next_state = st_xfer;
          end else begin
            next_blk = mix_out;
            next_state = (idx == len) ? st_tag : st_absorb;
          end
        end
      end
      st_xfer: begin
        // Same XOR both ways, so decrypt equals encrypt
        eng_raddr = cur.src[9:0] + {2'h0, idx};
        eng_waddr = dst_eff[9:0] + {2'h0, idx};
        eng_we = 1'b1;
        eng_wdata = eng_q ^ ks[pos*8 +: 8];
        next_idx = idx + 8'h01;
        next_pos = pos + 4'h1;
        if (next_idx == {1'b0, cur.cnt}) begin
          next_state = st_finish;
        end else if (pos == `CM_LAST_POS) begin
          {next_blk[119:112], next_blk[127:120]} =
            {blk[119:112], blk[127:120]} + 16'h0001;
          next_launch = 1'b1;
          next_state = st_cipher;
        end
      end
      st_absorb: begin
        eng_raddr = cur.src[9:0] + {2'h0, idx} - {9'h0, prefix};
        next_blk[pos*8 +: 8] = blk[pos*8 +: 8] ^ byte_in;
        next_idx = idx + 8'h01;
        next_pos = pos + 4'h1;
        if (pos == `CM_LAST_POS || next_idx == len) begin
          next_launch = 1'b1;
          next_state = st_cipher;
        end
      end
      st_tag: begin
        if (tag_len == 5'h00) begin
          next_state = st_finish;
        end else begin
          eng_waddr = dst_eff[9:0] + {6'h0, pos};
          eng_we = 1'b1;
          eng_wdata = blk[pos*8 +: 8];
          next_pos = pos + 4'h1;
          if ({1'b0, pos} == tag_len - 5'h01) begin
            next_state = st_finish;
          end
        end
      end
      st_finish: begin
        next_eng_ev[cur_prio ? `CM_EV_DONE_H : `CM_EV_DONE_L] = 1'b1;
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      cur <= '0;
      cur_prio <= 1'b0;
      key <= 128'h0;
      blk <= 128'h0;
      ks <= 128'h0;
      idx <= 8'h00;
      len <= 8'h00;
      pos <= 4'h0;
      tag_len <= 5'h00;
      dst_eff <= 12'h000;
      launch <= 1'b0;
      eng_ev <= '0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      cur_prio <= next_cur_prio;
      key <= next_key;
      blk <= next_blk;
      ks <= next_ks;
      idx <= next_idx;
      len <= next_len;
      pos <= next_pos;
      tag_len <= next_tag_len;
      dst_eff <= next_dst_eff;
      launch <= next_launch;
      eng_ev <= next_eng_ev;
    end
  end

endmodule // ctr_decrypt_cbc_mac_unit

`default_nettype wire

// ---- src/ctr_mac_map.svh ----
/*
  Register offsets, field positions and sizes of the counter-mode
  decryption and chained MAC unit. Assumes a 13-bit APB byte address.
*/
`ifndef CTR_MAC_MAP_SVH
`define CTR_MAC_MAP_SVH

// Register byte offsets
`define CM_REG_CMD 13'h0000
`define CM_REG_KEY_SLOT 13'h0004
`define CM_REG_COUNT 13'h0008
`define CM_REG_CTR_SLOT 13'h000C
`define CM_REG_SRC 13'h0010
`define CM_REG_DST 13'h0014
`define CM_REG_MODE 13'h0018
`define CM_REG_STATUS 13'h001C
`define CM_REG_MASK 13'h0020
`define CM_REG_ACTIVE 13'h0024
// RAM window: one byte per word from this bit upward
`define CM_RAM_SEL_BIT 12
`define CM_RAM_BYTES 13'h0300
`define CM_RAM_AW 10
// Command fields
`define CM_CMD_OP 1:0
`define CM_CMD_PRIO 4
// Event bits of the status and mask registers
`define CM_EV_W 5
`define CM_EV_DONE_L 0
`define CM_EV_DONE_H 1
`define CM_EV_BUSY 2
`define CM_EV_MEMADDR 3
`define CM_EV_OPERAND 4
// Slots are 16 bytes each; slots beyond RAM are illegal
`define CM_SLOT_SHIFT 4
`define CM_SLOT_LIMIT 8'h30
`define CM_LAST_POS 4'hF
// Integrity code lengths for mode bits 1:0 equal to 1, 2, 3
`define CM_TAG_LEN1 5'h04
`define CM_TAG_LEN2 5'h08
`define CM_TAG_LEN3 5'h10
`define CM_MODE_NOPREFIX 2
`define CM_CIPHER_ROUNDS 10

`endif

// ---- src/ctr_mac_pkg.sv ----
/*
  Types of the counter-mode decryption and chained MAC unit.
  Assumes ctr_mac_map.svh for the numeric constants.
*/
package ctr_mac_pkg;

  typedef enum logic [1:0] {
    op_none = 2'h0,
    counter_decrypt_op = 2'h1,
    chained_mac_auth_op = 2'h2,
    counter_encrypt_op = 2'h3
  } op_type;

  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_check = 9'h002,
    st_key = 9'h004,
    st_ctr = 9'h008,
    st_cipher = 9'h010,
    st_xfer = 9'h020,
    st_absorb = 9'h040,
    st_tag = 9'h080,
    st_finish = 9'h100
  } eng_state_type;

  typedef struct packed {
    op_type op;
    logic [7:0] key;
    logic [6:0] cnt;
    logic [7:0] ctr;
    logic [11:0] src;
    logic [11:0] dst;
    logic [2:0] mode;
  } instr_type;

endpackage

// ---- tb/ctr_decrypt_cbc_mac_unit_test.sv ----
/*
  Self-checking bench of the counter decryption and MAC unit.
  Assumes host_apb_model as the APB master and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ctr_mac_map.svh"

module ctr_decrypt_cbc_mac_unit_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] b;
  logic [7:0] plain [20];
  logic [7:0] tag_a [16];
  int errors, checks, len;

  ctr_decrypt_cbc_mac_unit ctr_decrypt_cbc_mac_unit_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  host_apb_model host_apb_model_inst (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #2.5 pclk = ~pclk;

  task automatic final_report();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic guard();
    if (host_apb_model_inst.timeouts != 0) begin
      errors++;
      final_report();
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host_apb_model_inst.xfer(1'b1, a, d, r, e);
    guard();
  endtask

  task automatic rd(input logic [12:0] a, output logic [31:0] r,
      output logic e);
    host_apb_model_inst.xfer(1'b0, a, 32'h0, r, e);
    guard();
  endtask

  function automatic logic [12:0] ram(input int i);
    return 13'h1000 + 13'(i * 4);
  endfunction

  task automatic rb(input int i, output logic [7:0] v);
    logic e;
    rd(ram(i), q, e);
    v = q[7:0];
  endtask

  // Poll status until all given event bits are set
  task automatic wait_ev(input logic [4:0] bits);
    logic e;
    int n;
    n = 0;
    q = 32'h0;
    while ((q[4:0] & bits) !== bits && n < 300) begin
      rd(`CM_REG_STATUS, q, e);
      n++;
    end
    if ((q[4:0] & bits) !== bits) begin
      errors++;
      final_report();
    end
  endtask

  task automatic st_chk(input logic [4:0] ev);
    logic e;
    rd(`CM_REG_STATUS, q, e);
    check(q, {27'h0, ev});
    wr(`CM_REG_STATUS, 32'h1F);
  endtask

  task automatic run(input logic p, input logic [1:0] op,
      input logic [7:0] k, input logic [6:0] c, input logic [11:0] s,
      input logic [11:0] d, input logic [2:0] m, input logic [4:0] ev);
    host_apb_model_inst.issue(p, op, k, c, 8'h03, s, d, m);
    wait_ev(p ? 5'h02 : 5'h01);
    st_chk(ev);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    errors = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(13'h0028, q, err);
    check({q[30:0], err}, 32'h1);
    rd(ram(768), q, err);
    check({q[30:0], err}, 32'h1);
    // Command with no operation is ignored
    wr(`CM_REG_CMD, 32'h10);
    rd(`CM_REG_ACTIVE, q, err);
    check(q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr(ram(32 + i), 32'(i));
      wr(ram(48 + i), 32'(8'hA0 + i));
    end
    for (int i = 0; i < 20; i++) begin
      plain[i] = 8'(i * 7 + 3);
      wr(ram(100 + i), 32'(plain[i]));
    end
    wr(ram(220), 32'h5A);
    // Encrypt to 200 while events are masked
    host_apb_model_inst.issue(1'b0, 2'h3, 8'h02, 7'd20, 8'h03, 12'd100,
      12'd200, 3'h0);
    wait_ev(5'h01);
    wr(`CM_REG_MASK, 32'h0);
    check(32'(irq), 32'h0);
    wr(`CM_REG_MASK, 32'h1F);
    rd(`CM_REG_MASK, q, err);
    check(q, 32'h1F);
    check(32'(irq), 32'h1);
    st_chk(5'h01);
    rd(`CM_REG_STATUS, q, err);
    check(q, 32'h0);
    check(32'(irq), 32'h0);
    run(1'b1, 2'h1, 8'h02, 7'd20, 12'd100, 12'd300, 3'h0, 5'h02);
    for (int i = 0; i < 20; i++) begin
      rb(200 + i, b);
      rb(300 + i, tag_a[0]);
      check(32'(tag_a[0]), 32'(b));
    end
    run(1'b0, 2'h1, 8'h02, 7'd20, 12'd200, 12'd0, 3'h0, 5'h01);
    for (int i = 0; i < 20; i++) begin
      rb(200 + i, b);
      check(32'(b), 32'(plain[i]));
    end
    rb(220, b);
    check(32'(b), 32'h5A);
    // Every tag length, guard byte just past the tag
    for (int m = 0; m < 4; m++) begin
      len = (m == 0) ? 0 : (m == 1) ? 4 : (m == 2) ? 8 : 16;
      wr(ram(400 + len), 32'h5A);
      run(1'b1, 2'h2, 8'h02, 7'd20, 12'd100, 12'd400, 3'(m), 5'h02);
      rb(400 + len, b);
      check(32'(b), 32'h5A);
    end
    for (int i = 0; i < 16; i++)
      rb(400 + i, tag_a[i]);
    wr(ram(136), 32'h5A);
    run(1'b1, 2'h2, 8'h02, 7'd20, 12'd100, 12'd0, 3'h3, 5'h02);
    for (int i = 0; i < 16; i++) begin
      rb(120 + i, b);
      check(32'(b), 32'(tag_a[i]));
    end
    rb(136, b);
    check(32'(b), 32'h5A);
    run(1'b1, 2'h2, 8'h02, 7'd20, 12'd100, 12'd440, 3'h7, 5'h02);
    len = 0;
    for (int i = 0; i < 16; i++) begin
      rb(440 + i, b);
      if (b !== tag_a[i])
        len++;
    end
    check(32'(len != 0), 32'h1);
    run(1'b0, 2'h2, 8'h02, 7'd0, 12'd100, 12'd400, 3'h5, 5'h11);
    wr(ram(500), 32'h5A);
    run(1'b0, 2'h1, 8'h02, 7'd20, 12'd760, 12'd500, 3'h0, 5'h09);
    run(1'b1, 2'h1, 8'h30, 7'd20, 12'd100, 12'd500, 3'h0, 5'h0A);
    rb(500, b);
    check(32'(b), 32'h5A);
    // Second low-priority issue while the first still runs
    host_apb_model_inst.issue(1'b0, 2'h1, 8'h02, 7'd127, 8'h03, 12'd600,
      12'd0, 3'h0);
    rd(`CM_REG_ACTIVE, q, err);
    check(q & 32'h1, 32'h1);
    host_apb_model_inst.issue(1'b0, 2'h1, 8'h02, 7'd127, 8'h03, 12'd600,
      12'd0, 3'h0);
    wait_ev(5'h05);
    st_chk(5'h05);
    final_report();
  end
endmodule // ctr_decrypt_cbc_mac_unit_test

`default_nettype wire

// ---- tb/ctr_mac_checker_asserts.sv ----
/*
  Port checks of the unit: APB answer timing, error flag, interrupt.
  Assumes the register map of ctr_mac_map.svh; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ctr_mac_map.svh"

module ctr_mac_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_one_wait: assert property ((psel && !penable) ##1 (psel && penable)
    |=> pready) else $error("no answer one cycle into access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_sel: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_ram_upper: assert property (pready && !pwrite && paddr[12]
    |-> prdata[31:8] == 24'h0) else $error("ram read upper bits set");
  chk_ram_range: assert property (pready && paddr[12] && paddr[1:0] == 2'h0
    |-> pslverr == (paddr[11:2] > 10'h2FF)) else $error("ram range error");
  chk_unmapped: assert property (pready && !paddr[12] && paddr[1:0] == 2'h0
    && paddr > `CM_REG_ACTIVE |-> pslverr) else $error("unmapped accepted");
  chk_mask_off: assert property (pready && pwrite && paddr == `CM_REG_MASK
    && pwdata[4:0] == 5'h0 |-> ##2 !irq [*2])
    else $error("irq with all events masked");
endmodule // ctr_mac_checker

bind ctr_decrypt_cbc_mac_unit ctr_mac_checker ctr_mac_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

`default_nettype wire

// ---- tb/host_apb_model.sv ----
/*
  Host model: APB master that issues instructions to the unit.
  Assumes ctr_mac_map.svh and the unit's one-wait-state slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ctr_mac_map.svh"

module host_apb_model (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [12:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int timeouts;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 13'h0000;
    pwdata = 32'h0;
    timeouts = 0;
  end

  task automatic xfer(input logic w, input logic [12:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1)
      timeouts++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic issue(input logic p, input logic [1:0] op,
      input logic [7:0] k, input logic [6:0] c, input logic [7:0] n,
      input logic [11:0] s, input logic [11:0] d, input logic [2:0] m);
    logic [31:0] q;
    logic e;
    xfer(1'b1, `CM_REG_KEY_SLOT, {24'h0, k}, q, e);
    xfer(1'b1, `CM_REG_COUNT, {25'h0, c}, q, e);
    xfer(1'b1, `CM_REG_CTR_SLOT, {24'h0, n}, q, e);
    xfer(1'b1, `CM_REG_SRC, {20'h0, s}, q, e);
    xfer(1'b1, `CM_REG_DST, {20'h0, d}, q, e);
    xfer(1'b1, `CM_REG_MODE, {29'h0, m}, q, e);
    xfer(1'b1, `CM_REG_CMD, {27'h0, p, 2'h0, op}, q, e);
  endtask
endmodule // host_apb_model

`default_nettype wire
